// *** pkg/stt_pkg.sv ***
// Purpose: Shared constants and types for the scheduling tick timer
// Assumes: clk is the internal processor clock (half the external rate)
// Notes: Register offsets are byte addresses on the plain register port
package stt_pkg;

    // ****************
    // Timing
    // ****************
    localparam int EXT_CLKS_PER_TICK = 256;
    localparam int INT_CLKS_PER_TICK = EXT_CLKS_PER_TICK / 2;
    localparam int TICKS_PER_IDLE_UPD = 32;
    localparam int SLICE_W = 16;
    localparam int MIN_SLICE_TICKS = 16;

    // ****************
    // Register map
    // ****************
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_NEXT_SLICE = 8'h04;
    localparam logic [ADDR_W-1:0] REG_REMAIN_SLICE = 8'h08;
    localparam logic [ADDR_W-1:0] REG_IDLE_TIME = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] REG_MASK = 8'h14;
    localparam logic [ADDR_W-1:0] REG_TICK_COUNT = 8'h18;

    localparam int CTRL_W = 3;
    localparam int STAT_W = 4;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;
    localparam logic [STAT_W-1:0] STAT_RESET = 4'h0;
    localparam logic [STAT_W-1:0] MASK_RESET = 4'h0;
    localparam logic [SLICE_W-1:0] SLICE_RESET = 16'h0010;

    // Control bits, msb first
    typedef struct packed {
        logic idle_count_en;
        logic slice_evt_en;
        logic exec_timer_en;
    } stt_ctrl_t;

    // Sticky event bits, msb first
    typedef struct packed {
        logic suspended;
        logic lock_granted;
        logic idle_updated;
        logic slice_expired;
    } stt_status_t;

    // Lock spin states, Gray along idle-try-wait-suspend
    typedef enum logic [1:0] {
        LK_IDLE = 2'h0,
        LK_TRY = 2'h1,
        LK_WAIT = 2'h3,
        LK_SUSP = 2'h2
    } stt_lock_state_t;

endpackage

// *** verilog/stt_tick_gen.sv ***
// Purpose: Prescaler that turns the internal clock into scheduling ticks
// Assumes: Reset already synchronised by the caller
// Notes: Tick is a one-cycle pulse, counted only while ce is high
`timescale 1ns/10ps
`default_nettype none
module stt_tick_gen #(
    parameter int DIV = stt_pkg::INT_CLKS_PER_TICK
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Tick
    output logic tick
);
    import stt_pkg::*;

    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    generate
        if (DIV < 2) begin : g_bad_div
            $error("stt_tick_gen: DIV must be at least 2");
        end
    endgenerate

    logic [CW-1:0] phase;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= '0;
        end else if (ce) begin
            phase <= (phase == LAST) ? '0 : phase + 1'b1;
        end
    end

    assign tick = ce && (phase == LAST);

endmodule
`default_nettype wire

// *** verilog/stt_timer.sv ***
// Purpose: Scheduling tick, time slice, idle polling and lock retry pacing
// Assumes: Register strobes are one cycle and never together
// Notes: Read data stand only in the cycle after the read strobe
`timescale 1ns/10ps
`default_nettype none
// Contract
// - A scheduling tick occurs every 256 external or 128 internal clock periods.
// - Only the low 16 bits of the next and remaining slice fields are used.
// - While idle, the dispatch port is polled once per tick.
// - While idle counting is on, the idle-time field is updated every 32 ticks.
// - A message operation meeting a held lock retries it once per tick until taken.
// - With timer and expiry event on, a spinning message operation may be suspended and retries on redispatch.
// - Any other held lock is retried once per tick until taken.
module stt_timer #(
    parameter int TICK_DIV = stt_pkg::INT_CLKS_PER_TICK,
    parameter int IDLE_TICKS = stt_pkg::TICKS_PER_IDLE_UPD
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // Register port
    input wire logic [stt_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Processor state
    input wire logic cpu_idle,
    output logic dispatch_poll,
    // Lock pacing
    input wire logic lock_req,
    input wire logic lock_is_msg,
    input wire logic lock_held,
    input wire logic redispatch,
    output logic lock_try,
    output logic lock_grant,
    output logic suspend_req,
    // Events
    output logic slice_expire,
    output logic irq
);
    import stt_pkg::*;

    localparam int IW = $clog2(IDLE_TICKS);
    localparam logic [IW-1:0] IDLE_LAST = IW'(IDLE_TICKS - 1);

    generate
        if (IDLE_TICKS < 2 || (1 << IW) != IDLE_TICKS) begin : g_bad_idle
            $error("stt_timer: IDLE_TICKS must be a power of two of at least 2");
        end
    endgenerate

    // ****************
    // Reset release
    // ****************
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ****************
    // Tick
    // ****************
    logic tick;

    stt_tick_gen #(
        .DIV(TICK_DIV)
    ) u_tick (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .tick(tick)
    );

    // ****************
    // Registers
    // ****************
    stt_ctrl_t ctrl;
    stt_status_t status;
    stt_status_t mask;
    stt_status_t events;
    logic [SLICE_W-1:0] next_slice;
    logic [SLICE_W-1:0] remain;
    logic [31:0] idle_time;
    logic [31:0] tick_count;

    function automatic logic hit(input logic [ADDR_W-1:0] a);
        return ce && reg_wr && (reg_addr == a);
    endfunction

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= CTRL_RESET;
            mask <= MASK_RESET;
            next_slice <= SLICE_RESET;
        end else begin
            if (hit(REG_CTRL)) begin
                ctrl <= reg_wdata[CTRL_W-1:0];
            end
            if (hit(REG_MASK)) begin
                mask <= reg_wdata[STAT_W-1:0];
            end
            // Upper half of the slice word is dropped
            if (hit(REG_NEXT_SLICE)) begin
                next_slice <= reg_wdata[SLICE_W-1:0];
            end
        end
    end

    // Sticky status: a new event wins over a write-one clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status <= STAT_RESET;
        end else if (ce) begin
            if (hit(REG_STATUS)) begin
                status <= (status & ~stt_status_t'(reg_wdata[STAT_W-1:0])) | events;
            end else begin
                status <= status | events;
            end
        end
    end

    assign irq = |(status & mask);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (ce) begin
            reg_rdata <= '0;
            if (reg_rd) begin
                unique case (reg_addr)
                    REG_CTRL: reg_rdata <= 32'(ctrl);
                    REG_NEXT_SLICE: reg_rdata <= 32'(next_slice);
                    REG_REMAIN_SLICE: reg_rdata <= 32'(remain);
                    REG_IDLE_TIME: reg_rdata <= idle_time;
                    REG_STATUS: reg_rdata <= 32'(status);
                    REG_MASK: reg_rdata <= 32'(mask);
                    REG_TICK_COUNT: reg_rdata <= tick_count;
                    default: reg_rdata <= '0;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_count <= '0;
        end else if (tick) begin
            tick_count <= tick_count + 32'h00000001;
        end
    end

    // ****************
    // Time slice
    // ****************
    // A slice below the minimum is not clamped; software must keep it legal.
    logic slice_zero;
    assign slice_zero = (remain == SLICE_W'(1));
    assign slice_expire = tick && ctrl.exec_timer_en && slice_zero && ctrl.slice_evt_en;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            remain <= SLICE_RESET;
        end else if (hit(REG_REMAIN_SLICE)) begin
            remain <= reg_wdata[SLICE_W-1:0];
        end else if (tick && ctrl.exec_timer_en && remain != '0) begin
            // Reload from the next slice as the count runs out
            remain <= slice_zero ? next_slice : remain - 1'b1;
        end
    end

    // ****************
    // Idle handling
    // ****************
    logic [IW-1:0] idle_phase;
    logic [31:0] idle_pending;
    logic idle_update;

    assign dispatch_poll = tick && cpu_idle;
    assign idle_update = tick && ctrl.idle_count_en && idle_phase == IDLE_LAST;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_phase <= '0;
        end else if (tick && ctrl.idle_count_en) begin
            idle_phase <= idle_phase + 1'b1;
        end
    end

    // Idle ticks gather here and reach the visible field in batches
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_pending <= '0;
            idle_time <= '0;
        end else begin
            if (idle_update) begin
                idle_pending <= 32'(cpu_idle);
                idle_time <= idle_time + idle_pending;
            end else if (tick && ctrl.idle_count_en && cpu_idle) begin
                idle_pending <= idle_pending + 32'h00000001;
            end
            if (hit(REG_IDLE_TIME)) begin
                idle_time <= reg_wdata;
            end
        end
    end

    // ****************
    // Lock spin
    // ****************
    stt_lock_state_t lk_state;
    stt_lock_state_t next_lk_state;
    logic may_suspend;

    assign may_suspend = lock_is_msg && ctrl.exec_timer_en && ctrl.slice_evt_en;
    assign lock_try = ce && lk_state == LK_TRY;
    assign lock_grant = lock_try && !lock_held;
    assign suspend_req = ce && lk_state == LK_WAIT && lock_req && may_suspend
        && slice_expire;

    always_comb begin
        next_lk_state = lk_state;
        unique case (lk_state)
            LK_IDLE: begin
                if (lock_req) begin
                    next_lk_state = LK_TRY;
                end
            end
            LK_TRY: begin
                next_lk_state = lock_held ? LK_WAIT : LK_IDLE;
            end
            LK_WAIT: begin
                if (!lock_req) begin
                    next_lk_state = LK_IDLE;
                end else if (suspend_req) begin
                    next_lk_state = LK_SUSP;
                end else if (tick) begin
                    next_lk_state = LK_TRY;
                end
            end
            LK_SUSP: begin
                if (!lock_req) begin
                    next_lk_state = LK_IDLE;
                end else if (redispatch) begin
                    next_lk_state = LK_TRY;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lk_state <= LK_IDLE;
        end else if (ce) begin
            lk_state <= next_lk_state;
        end
    end

    always_comb begin
        events = STAT_RESET;
        events.slice_expired = slice_expire;
        events.idle_updated = idle_update;
        events.lock_granted = lock_grant;
        events.suspended = suspend_req;
    end

    // ****************
    // Checks
    // ****************
    logic [7:0] since_tick;

    // The spacing checker counts in eight bits only
    generate
        if (TICK_DIV > (1 << $bits(since_tick))) begin : g_bad_chk_div
            $error("stt_timer: TICK_DIV beyond the tick checker range");
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            since_tick <= '0;
        end else if (ce) begin
            since_tick <= tick ? '0 : since_tick + 8'h01;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_spin;
        ce && lk_state == LK_WAIT && lock_req && !suspend_req && !tick;
    endsequence

    sequence s_retry;
        ce && lk_state == LK_WAIT && lock_req && tick && !suspend_req;
    endsequence

    property p_tick_period;
        tick |-> since_tick == 8'(TICK_DIV - 1);
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("tick spacing wrong");

    property p_slice_upper;
        ce && reg_rd && reg_addr == REG_NEXT_SLICE |=> reg_rdata[31:SLICE_W] == '0;
    endproperty
    a_slice_upper: assert property (p_slice_upper) else $error("slice upper bits");

    property p_poll;
        dispatch_poll |-> cpu_idle && since_tick == 8'(TICK_DIV - 1);
    endproperty
    a_poll: assert property (p_poll) else $error("idle poll not on tick");

    property p_idle_upd;
        idle_update |-> tick && idle_phase == IDLE_LAST;
    endproperty
    a_idle_upd: assert property (p_idle_upd) else $error("idle update spacing");

    // A frozen cycle may follow; the try then waits for ce
    property p_retry;
        s_retry |=> !ce || lock_try;
    endproperty
    a_retry: assert property (p_retry) else $error("lock not retried on tick");

    property p_no_early_try;
        s_spin |=> !lock_try;
    endproperty
    a_no_early_try: assert property (p_no_early_try) else $error("early retry");

    property p_suspend;
        suspend_req |=> lk_state == LK_SUSP ##0 !lock_try;
    endproperty
    a_suspend: assert property (p_suspend) else $error("suspend not taken");

    property p_resume;
        ce && lk_state == LK_SUSP && lock_req && redispatch |=> !ce || lock_try;
    endproperty
    a_resume: assert property (p_resume) else $error("no retry on redispatch");

    property p_reload;
        tick && ctrl.exec_timer_en && slice_zero && !hit(REG_REMAIN_SLICE)
            |=> remain == $past(next_slice);
    endproperty
    a_reload: assert property (p_reload) else $error("slice not reloaded");

    // An event in the cycle of a clear must still leave its bit set
    property p_irq;
        |events |=> (status & $past(events)) == $past(events);
    endproperty
    a_irq: assert property (p_irq) else $error("event lost to a clear");

endmodule
`default_nettype wire

// *** tb/stt_timer_tb.sv ***
// Purpose: Self-checking bench for the scheduling tick timer
// Assumes: Short prescaler and idle batch so the run stays brief
// Notes: Read results are compared by a monitor from a queue of notes
`timescale 1ns/10ps
`default_nettype none
module stt_timer_tb;
    import stt_pkg::*;
    localparam int DIV = 4;
    localparam int IDL = 4;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic ce = 1'b1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic cpu_idle = 1'b0;
    logic lock_req = 1'b0;
    logic lock_is_msg = 1'b0;
    logic lock_held = 1'b0;
    logic redispatch = 1'b0;
    logic dispatch_poll;
    logic lock_try;
    logic lock_grant;
    logic suspend_req;
    logic slice_expire;
    logic irq;
    logic chk_rd = 1'b0;
    logic chk_d = 1'b0;
    logic [31:0] exp_q[$];
    int n_fail = 0;
    int n_checks = 0;
    int seed = 53611;
    int cyc = 0;

    always #10 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    stt_timer #(.TICK_DIV(DIV), .IDLE_TICKS(IDL)) dut (
        .clk(clk), .arst_n(arst_n), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cpu_idle(cpu_idle), .dispatch_poll(dispatch_poll),
        .lock_req(lock_req), .lock_is_msg(lock_is_msg), .lock_held(lock_held),
        .redispatch(redispatch), .lock_try(lock_try), .lock_grant(lock_grant),
        .suspend_req(suspend_req), .slice_expire(slice_expire), .irq(irq)
    );

    // ****************
    // Checking
    // ****************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Read data stand only in the cycle after the strobe
    always @(posedge clk) chk_d <= reg_rd && chk_rd;
    always @(negedge clk) begin
        if (chk_d) begin
            if (exp_q.size() == 0) begin
                check("read note", 32'h1, 32'h0);
            end else begin
                check("reg_rdata", reg_rdata, exp_q.pop_front());
            end
        end
    end

    // ****************
    // Bus and waits
    // ****************
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        chk_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        logic [31:0] d;
        exp_q.push_back(e);
        chk_rd <= 1'b1;
        rd(a, d);
    endtask

    // Pulses are combinational, so look at them mid-cycle
    task automatic wait_on(input int which, input int lim, output int n);
        logic s;
        n = 0;
        do begin
            @(negedge clk);
            n++;
            case (which)
                0: s = dispatch_poll;
                1: s = irq;
                2: s = lock_try;
                3: s = slice_expire;
                default: s = suspend_req;
            endcase
        end while (s !== 1'b1 && n < lim);
        if (s !== 1'b1) begin
            check("wait bound", 32'h0, 32'h1);
            complete_run();
        end
    endtask

    // ****************
    // Scenarios
    // ****************
    initial begin
        logic [31:0] v;
        logic [31:0] v2;
        int n;
        int t1;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd_chk(REG_CTRL, 32'h0);
        rd_chk(REG_NEXT_SLICE, 32'h10);
        rd_chk(REG_REMAIN_SLICE, 32'h10);
        rd_chk(REG_IDLE_TIME, 32'h0);
        rd_chk(REG_STATUS, 32'h0);
        rd_chk(REG_MASK, 32'h0);
        rd_chk(8'h1C, 32'h0);
        // Upper halves carry noise that must vanish
        v = $random(seed);
        wr(REG_NEXT_SLICE, {v[31:16], 16'h0010});
        rd_chk(REG_NEXT_SLICE, 32'h10);
        wr(REG_REMAIN_SLICE, {~v[31:16], 16'h0003});
        rd_chk(REG_REMAIN_SLICE, 32'h3);
        wr(REG_MASK, 32'h1);
        wr(REG_CTRL, 32'h3);
        wait_on(3, 3 * DIV + 4, n);
        wait_on(3, 16 * DIV + 2, n);
        check("slice period", 32'(n), 32'(16 * DIV));
        rd_chk(REG_REMAIN_SLICE, 32'h10);
        rd_chk(REG_STATUS, 32'h1);
        check("irq raised", irq, 1'b1);
        wr(REG_CTRL, 32'h0);
        wr(REG_STATUS, 32'h1);
        @(negedge clk);
        check("irq cleared", irq, 1'b0);
        // Strobes while frozen are dropped
        @(posedge clk);
        ce <= 1'b0;
        wr(REG_MASK, 32'hF);
        ce <= 1'b1;
        rd_chk(REG_MASK, 32'h1);
        // Read strobes exactly two tick periods apart
        rd(REG_TICK_COUNT, v);
        repeat (2 * DIV - 2) @(posedge clk);
        rd(REG_TICK_COUNT, v2);
        check("tick count", v2 - v, 32'h2);
        @(posedge clk);
        cpu_idle <= 1'b1;
        wait_on(0, DIV + 2, n);
        wait_on(0, DIV + 2, n);
        check("tick spacing", 32'(n), 32'(DIV));
        @(posedge clk);
        cpu_idle <= 1'b0;
        v = 0;
        repeat (3 * DIV) begin
            @(negedge clk);
            v += 32'(dispatch_poll);
        end
        check("busy polls", v, 32'h0);
        @(posedge clk);
        cpu_idle <= 1'b1;
        wr(REG_MASK, 32'h2);
        wr(REG_CTRL, 32'h4);
        wait_on(1, (IDL + 1) * DIV + 4, n);
        t1 = cyc;
        rd(REG_IDLE_TIME, v);
        wr(REG_STATUS, 32'h2);
        wait_on(1, IDL * DIV + 2, n);
        check("idle update period", 32'(cyc - t1), 32'(IDL * DIV));
        rd(REG_IDLE_TIME, v2);
        check("idle batch", v2 - v, 32'(IDL));
        wr(REG_CTRL, 32'h0);
        wr(REG_MASK, 32'h0);
        @(negedge clk);
        check("irq masked", irq, 1'b0);
        rd_chk(REG_STATUS, 32'h2);
        wr(REG_STATUS, 32'hF);
        for (int m = 0; m < 2; m++) begin
            @(posedge clk);
            lock_is_msg <= m[0];
            lock_held <= 1'b1;
            lock_req <= 1'b1;
            wait_on(2, 3, n);
            check("first try", 32'(n), 32'h2);
            check("held no grant", lock_grant, 1'b0);
            // First retry lands on the tick phase; measure the next one
            wait_on(2, DIV + 2, n);
            wait_on(2, DIV + 2, n);
            check("retry spacing", 32'(n), 32'(DIV));
            @(posedge clk);
            lock_held <= 1'b0;
            wait_on(2, DIV + 2, n);
            check("grant", lock_grant, 1'b1);
            @(posedge clk);
            lock_req <= 1'b0;
            rd_chk(REG_STATUS, 32'h4);
            wr(REG_STATUS, 32'h4);
        end
        // Spinning message op with a nearly spent slice
        wr(REG_REMAIN_SLICE, 32'h2);
        wr(REG_CTRL, 32'h3);
        @(posedge clk);
        lock_is_msg <= 1'b1;
        lock_held <= 1'b1;
        lock_req <= 1'b1;
        wait_on(4, 4 * DIV, n);
        check("suspend on expiry", slice_expire, 1'b1);
        v = 0;
        repeat (3 * DIV) begin
            @(negedge clk);
            v += 32'(lock_try);
        end
        check("no try while suspended", v, 32'h0);
        @(posedge clk);
        lock_held <= 1'b0;
        redispatch <= 1'b1;
        @(posedge clk);
        redispatch <= 1'b0;
        @(negedge clk);
        check("retry on redispatch", lock_try, 1'b1);
        check("grant on redispatch", lock_grant, 1'b1);
        @(posedge clk);
        lock_req <= 1'b0;
        rd_chk(REG_STATUS, 32'hD);
        complete_run();
    end
endmodule
`default_nettype wire
